// >>> spmd_top.sv
// dma serial master: registers, transaction sequencer, memory channels and pins
`timescale 1ns/1ps
module spmd_top
	import spmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	output logic sck_out,
	output logic sck_oe,
	output logic dout_out,
	output logic dout_oe,
	input wire logic din_in,
	output logic [31:0] sck_pin_sel,
	output logic [31:0] dout_pin_sel,
	output logic [31:0] din_pin_sel
);
	logic [4:0] ev_r;
	logic [4:0] ev_pulse_r;
	logic [4:0] irq_en_r;
	logic link_r;
	logic [3:0] enable_r;
	logic [31:0] psel_clk_r;
	logic [31:0] psel_dout_r;
	logic [31:0] psel_din_r;
	logic [31:0] rate_r;
	logic [31:0] rx_ptr_r;
	logic [14:0] rx_limit_r;
	logic [1:0] rx_list_r;
	logic [31:0] tx_ptr_r;
	logic [14:0] tx_limit_r;
	logic [1:0] tx_list_r;
	logic [2:0] format_r;
	logic [7:0] fill_r;
	logic [14:0] rx_done_r;
	logic [14:0] tx_done_r;
	logic [31:0] act_rx_ptr_r;
	logic [31:0] act_tx_ptr_r;
	logic [14:0] act_rx_limit_r;
	logic [14:0] act_tx_limit_r;
	logic [14:0] rx_cnt_r;
	logic [14:0] tx_cnt_r;
	logic tx_fin_r;
	logic rx_fin_r;
	logic end_given_r;
	logic stop_pend_r;
	logic susp_r;
	logic relink_r;
	spmd_state_type state_r;
	logic [7:0] shift_byte_r;
	logic shift_go_r;
	logic [9:0] div_r;
	logic tick_r;
	logic din_s1_r;
	logic din_s2_r;
	logic sh_done;
	logic sh_busy;
	logic [7:0] sh_rx;
	logic enabled;
	logic tsk_start;
	logic tsk_stop;
	logic tsk_suspend;
	logic tsk_resume;
	logic go;

	function automatic logic task_hit(input logic [11:0] a, input logic [11:0] ofs, input logic w, input logic d0);
		return w && (a == ofs) && d0;
	endfunction : task_hit

	assign enabled = (enable_r == ENABLE_ON);
	assign tsk_start = task_hit(reg_addr, OFS_START, reg_wr, reg_wdata[0]);
	assign tsk_stop = task_hit(reg_addr, OFS_STOP, reg_wr, reg_wdata[0]);
	assign tsk_suspend = task_hit(reg_addr, OFS_SUSPEND, reg_wr, reg_wdata[0]);
	assign tsk_resume = task_hit(reg_addr, OFS_RESUME, reg_wr, reg_wdata[0]);
	assign go = enabled && (tsk_start || relink_r);
	assign sck_pin_sel = psel_clk_r;
	assign dout_pin_sel = psel_dout_r;
	assign din_pin_sel = psel_din_r;

	// software writable configuration
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			irq_en_r <= 5'h00;
			link_r <= 1'b0;
			enable_r <= 4'h0;
			psel_clk_r <= PSEL_RST;
			psel_dout_r <= PSEL_RST;
			psel_din_r <= PSEL_RST;
			rate_r <= RATE_RST;
			rx_ptr_r <= 32'h00000000;
			rx_limit_r <= LIMIT_RST;
			rx_list_r <= 2'h0;
			tx_ptr_r <= 32'h00000000;
			tx_limit_r <= LIMIT_RST;
			tx_list_r <= 2'h0;
			format_r <= FORMAT_RST;
			fill_r <= FILL_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFS_LINKS: link_r <= reg_wdata[LINK_END_START];
				OFS_IRQ_SET: irq_en_r <= irq_en_r | reg_wdata[4:0];
				OFS_IRQ_CLR: irq_en_r <= irq_en_r & ~reg_wdata[4:0];
				OFS_ENABLE: enable_r <= reg_wdata[3:0];
				OFS_PSEL_CLK: psel_clk_r <= reg_wdata;
				OFS_PSEL_DOUT: psel_dout_r <= reg_wdata;
				OFS_PSEL_DIN: psel_din_r <= reg_wdata;
				OFS_BIT_RATE: rate_r <= reg_wdata;
				OFS_RX_PTR: rx_ptr_r <= reg_wdata;
				OFS_RX_LIMIT: rx_limit_r <= reg_wdata[14:0];
				OFS_RX_LIST: rx_list_r <= reg_wdata[1:0];
				OFS_TX_PTR: tx_ptr_r <= reg_wdata;
				OFS_TX_LIMIT: tx_limit_r <= reg_wdata[14:0];
				OFS_TX_LIST: tx_list_r <= reg_wdata[1:0];
				OFS_FORMAT: format_r <= reg_wdata[2:0];
				OFS_FILL: fill_r <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// sticky events: a hardware set beats a clearing write in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			ev_r <= 5'h00;
		else
		begin
			for (int i = 0; i < 5; i++)
			begin
				if (ev_pulse_r[i])
					ev_r[i] <= 1'b1;
				else if (reg_wr && reg_addr == EV_OFS[i] && reg_wdata == 32'h00000000)
					ev_r[i] <= 1'b0;
			end
		end
	end

	// read data stand in the cycle after the strobe only
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h00000000;
		else
		begin
			reg_rdata <= 32'h00000000;
			if (reg_rd)
			begin
				case (reg_addr)
					OFS_LINKS: reg_rdata <= {31'h0, link_r};
					OFS_IRQ_SET, OFS_IRQ_CLR: reg_rdata <= {27'h0, irq_en_r};
					OFS_ENABLE: reg_rdata <= {28'h0, enable_r};
					OFS_PSEL_CLK: reg_rdata <= psel_clk_r;
					OFS_PSEL_DOUT: reg_rdata <= psel_dout_r;
					OFS_PSEL_DIN: reg_rdata <= psel_din_r;
					OFS_BIT_RATE: reg_rdata <= rate_r;
					OFS_RX_PTR: reg_rdata <= rx_ptr_r;
					OFS_RX_LIMIT: reg_rdata <= {17'h0, rx_limit_r};
					OFS_RX_DONE: reg_rdata <= {17'h0, rx_done_r};
					OFS_RX_LIST: reg_rdata <= {30'h0, rx_list_r};
					OFS_TX_PTR: reg_rdata <= tx_ptr_r;
					OFS_TX_LIMIT: reg_rdata <= {17'h0, tx_limit_r};
					OFS_TX_DONE: reg_rdata <= {17'h0, tx_done_r};
					OFS_TX_LIST: reg_rdata <= {30'h0, tx_list_r};
					OFS_FORMAT: reg_rdata <= {29'h0, format_r};
					OFS_FILL: reg_rdata <= {24'h0, fill_r};
					default:
					begin
						for (int i = 0; i < 5; i++)
							if (reg_addr == EV_OFS[i])
								reg_rdata <= {31'h0, ev_r[i]};
					end
				endcase
			end
		end
	end

	// data in passes two flops before the shifter looks at it
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			din_s1_r <= 1'b0;
			din_s2_r <= 1'b0;
		end
		else
		begin
			din_s1_r <= din_in;
			din_s2_r <= din_s1_r;
		end
	end

	// half period enable for the serial clock
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || !sh_busy)
		begin
			div_r <= 10'h000;
			tick_r <= 1'b0;
		end
		else if (div_r == spmd_half(rate_r) - 10'h001)
		begin
			div_r <= 10'h000;
			tick_r <= 1'b1;
		end
		else
		begin
			div_r <= div_r + 10'h001;
			tick_r <= 1'b0;
		end
	end

	// pin drivers only act while the block is enabled
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sck_oe <= 1'b0;
			dout_oe <= 1'b0;
		end
		else
		begin
			sck_oe <= enabled && !psel_clk_r[PSEL_CONNECT];
			dout_oe <= enabled && !psel_dout_r[PSEL_CONNECT];
		end
	end

	spmd_shifter u_shift (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(shift_go_r),
		.tick(tick_r),
		.tx_byte(shift_byte_r),
		.cpol(format_r[FMT_POL]),
		.cpha(format_r[FMT_PHASE]),
		.lsb_first(format_r[FMT_ORDER]),
		.din(din_s2_r),
		.sck(sck_out),
		.dout(dout_out),
		.rx_byte(sh_rx),
		.done(sh_done),
		.busy(sh_busy)
	);

	// transaction sequencer
	always_ff @(posedge core_clk)
	begin
		logic [4:0] pul;
		pul = 5'h00;
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			ev_pulse_r <= 5'h00;
			act_rx_ptr_r <= 32'h00000000;
			act_tx_ptr_r <= 32'h00000000;
			act_rx_limit_r <= LIMIT_RST;
			act_tx_limit_r <= LIMIT_RST;
			rx_cnt_r <= 15'h0000;
			tx_cnt_r <= 15'h0000;
			rx_done_r <= 15'h0000;
			tx_done_r <= 15'h0000;
			tx_fin_r <= 1'b0;
			rx_fin_r <= 1'b0;
			end_given_r <= 1'b1;
			stop_pend_r <= 1'b0;
			susp_r <= 1'b0;
			relink_r <= 1'b0;
			shift_byte_r <= 8'h00;
			shift_go_r <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_wdata <= 8'h00;
		end
		else
		begin
			shift_go_r <= 1'b0;
			if (tx_fin_r && rx_fin_r && !end_given_r)
			begin
				pul[EV_BOTH_END] = 1'b1;
				end_given_r <= 1'b1;
				relink_r <= link_r;
			end
			if (state_r != ST_IDLE)
			begin
				if (tsk_stop)
					stop_pend_r <= 1'b1;
				if (tsk_suspend)
					susp_r <= 1'b1;
				else if (tsk_resume)
					susp_r <= 1'b0;
			end
			case (state_r)
				ST_IDLE:
				begin
					if (go)
					begin
						act_rx_ptr_r <= rx_ptr_r;
						act_tx_ptr_r <= tx_ptr_r;
						act_rx_limit_r <= rx_limit_r;
						act_tx_limit_r <= tx_limit_r;
						rx_cnt_r <= 15'h0000;
						tx_cnt_r <= 15'h0000;
						tx_fin_r <= 1'b0;
						rx_fin_r <= 1'b0;
						end_given_r <= 1'b0;
						stop_pend_r <= 1'b0;
						susp_r <= 1'b0;
						pul[EV_STARTED] = 1'b1;
						relink_r <= 1'b0; // a shortcut start is held until the sequencer is back in idle
						state_r <= ST_LOAD;
					end
					else if (tsk_stop)
						pul[EV_STOPPED] = 1'b1;
				end
				ST_LOAD:
				begin
					if (stop_pend_r || (tx_cnt_r >= act_tx_limit_r && rx_cnt_r >= act_rx_limit_r))
						state_r <= ST_HALT;
					else if (susp_r)
						state_r <= ST_LOAD;
					else if (tx_cnt_r < act_tx_limit_r)
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= act_tx_ptr_r + {17'h0, tx_cnt_r};
						state_r <= ST_RD;
					end
					else
					begin
						shift_byte_r <= fill_r;
						shift_go_r <= 1'b1;
						state_r <= ST_SHIFT;
					end
				end
				ST_RD:
				begin
					// byte taken as returned; contention on the memory side is not detected
					if (mem_ack)
					begin
						mem_req <= 1'b0;
						shift_byte_r <= mem_rdata;
						shift_go_r <= 1'b1;
						state_r <= ST_SHIFT;
					end
				end
				ST_SHIFT:
				begin
					if (sh_done)
					begin
						if (tx_cnt_r < act_tx_limit_r)
						begin
							tx_cnt_r <= tx_cnt_r + 15'h0001;
							if (tx_cnt_r + 15'h0001 == act_tx_limit_r)
							begin
								pul[EV_TX_END] = 1'b1;
								tx_fin_r <= 1'b1;
							end
						end
						if (rx_cnt_r < act_rx_limit_r)
						begin
							mem_req <= 1'b1;
							mem_we <= 1'b1;
							mem_addr <= act_rx_ptr_r + {17'h0, rx_cnt_r};
							mem_wdata <= sh_rx;
							state_r <= ST_WR;
						end
						else
							state_r <= ST_LOAD;
					end
				end
				ST_WR:
				begin
					if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						rx_cnt_r <= rx_cnt_r + 15'h0001;
						if (rx_cnt_r + 15'h0001 == act_rx_limit_r)
						begin
							pul[EV_RX_END] = 1'b1;
							rx_fin_r <= 1'b1;
						end
						state_r <= ST_LOAD;
					end
				end
				ST_HALT:
				begin
					pul[EV_TX_END] = !tx_fin_r;
					pul[EV_RX_END] = !rx_fin_r;
					tx_fin_r <= 1'b1;
					rx_fin_r <= 1'b1;
					tx_done_r <= tx_cnt_r;
					rx_done_r <= rx_cnt_r;
					pul[EV_STOPPED] = stop_pend_r;
					stop_pend_r <= 1'b0;
					susp_r <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
			ev_pulse_r <= pul;
		end
	end
endmodule : spmd_top

// >>> spmd_pkg.sv
// constants, register map and types for the dma serial master
package spmd_pkg;
	localparam logic [11:0] OFS_START = 12'h010;
	localparam logic [11:0] OFS_STOP = 12'h014;
	localparam logic [11:0] OFS_SUSPEND = 12'h01c;
	localparam logic [11:0] OFS_RESUME = 12'h020;
	localparam logic [11:0] OFS_STOPPED = 12'h104;
	localparam logic [11:0] OFS_RX_END = 12'h110;
	localparam logic [11:0] OFS_BOTH_END = 12'h118;
	localparam logic [11:0] OFS_TX_END = 12'h120;
	localparam logic [11:0] OFS_STARTED = 12'h14c;
	localparam logic [11:0] OFS_LINKS = 12'h200;
	localparam logic [11:0] OFS_IRQ_SET = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
	localparam logic [11:0] OFS_ENABLE = 12'h500;
	localparam logic [11:0] OFS_PSEL_CLK = 12'h508;
	localparam logic [11:0] OFS_PSEL_DOUT = 12'h50c;
	localparam logic [11:0] OFS_PSEL_DIN = 12'h510;
	localparam logic [11:0] OFS_BIT_RATE = 12'h524;
	localparam logic [11:0] OFS_RX_PTR = 12'h534;
	localparam logic [11:0] OFS_RX_LIMIT = 12'h538;
	localparam logic [11:0] OFS_RX_DONE = 12'h53c;
	localparam logic [11:0] OFS_RX_LIST = 12'h540;
	localparam logic [11:0] OFS_TX_PTR = 12'h544;
	localparam logic [11:0] OFS_TX_LIMIT = 12'h548;
	localparam logic [11:0] OFS_TX_DONE = 12'h54c;
	localparam logic [11:0] OFS_TX_LIST = 12'h550;
	localparam logic [11:0] OFS_FORMAT = 12'h554;
	localparam logic [11:0] OFS_FILL = 12'h5c0;
	// event index: stopped, rx end, both end, tx end, started
	localparam int EV_STOPPED = 0;
	localparam int EV_RX_END = 1;
	localparam int EV_BOTH_END = 2;
	localparam int EV_TX_END = 3;
	localparam int EV_STARTED = 4;
	localparam logic [11:0] EV_OFS [5] = '{OFS_STOPPED, OFS_RX_END, OFS_BOTH_END, OFS_TX_END, OFS_STARTED};
	localparam int FMT_ORDER = 0;
	localparam int FMT_PHASE = 1;
	localparam int FMT_POL = 2;
	localparam int LINK_END_START = 0;
	localparam int PSEL_CONNECT = 31;
	localparam logic [3:0] ENABLE_ON = 4'h1;
	localparam logic [31:0] PSEL_RST = 32'hffffffff;
	localparam logic [31:0] RATE_RST = 32'h04000000;
	localparam logic [2:0] FORMAT_RST = 3'h0;
	localparam logic [14:0] LIMIT_RST = 15'h0000;
	localparam logic [7:0] FILL_RST = 8'h00;
	localparam int CLK_HZ = 200_000_000;
	localparam int BITS_PER_BYTE = 8;
	// serial half period in core cycles, rounded up so the period never runs short
	function automatic logic [9:0] spmd_half(input logic [31:0] rate);
		int bps;
		bps = 250_000;
		case (rate)
			32'h02000000: bps = 125_000;
			32'h04000000: bps = 250_000;
			32'h08000000: bps = 500_000;
			32'h10000000: bps = 1_000_000;
			32'h20000000: bps = 2_000_000;
			32'h40000000: bps = 4_000_000;
			32'h80000000: bps = 8_000_000;
			default: bps = 250_000;
		endcase
		return 10'((CLK_HZ + 2 * bps - 1) / (2 * bps));
	endfunction : spmd_half
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_RD, ST_SHIFT, ST_WR, ST_HALT} spmd_state_type;
endpackage : spmd_pkg

// >>> spmd_shifter.sv
// one byte of full duplex shifting in any of the four clock modes
`timescale 1ns/1ps
module spmd_shifter
	import spmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic tick,
	input wire logic [7:0] tx_byte,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb_first,
	input wire logic din,
	output logic sck,
	output logic dout,
	output logic [7:0] rx_byte,
	output logic done,
	output logic busy
);
	logic [3:0] edge_r;
	logic [7:0] tx_r;
	logic [2:0] bit_r;

	function automatic logic pick(input logic [7:0] b, input logic [2:0] i, input logic lsb);
		return lsb ? b[i] : b[3'd7 - i];
	endfunction : pick

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			busy <= 1'b0;
			edge_r <= 4'h0;
			bit_r <= 3'h0;
			tx_r <= 8'h00;
			sck <= 1'b0;
			dout <= 1'b0;
			rx_byte <= 8'h00;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!busy)
			begin
				sck <= cpol;
				dout <= 1'b0;
				if (start)
				begin
					busy <= 1'b1;
					tx_r <= tx_byte;
					edge_r <= 4'h0;
					bit_r <= 3'h1;
					// leading phase puts the first bit out before the first edge
					if (!cpha)
						dout <= pick(tx_byte, 3'h0, lsb_first);
				end
			end
			else if (tick)
			begin
				sck <= ~sck;
				edge_r <= edge_r + 4'h1;
				// edge_r even is the leading edge
				if (edge_r[0] == cpha)
				begin
					if (lsb_first)
						rx_byte <= {din, rx_byte[7:1]};
					else
						rx_byte <= {rx_byte[6:0], din};
				end
				else if (cpha)
					dout <= pick(tx_r, edge_r[3:1], lsb_first);
				else if (edge_r != 4'hf)
				begin
					dout <= pick(tx_r, bit_r, lsb_first);
					bit_r <= bit_r + 3'h1;
				end
				if (edge_r == 4'hf)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : spmd_shifter

// >>> spmd_monitor.sv
// port assertions for the dma serial master
`timescale 1ns/1ps
module spmd_monitor
	import spmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic dout_out,
	input wire logic dout_oe,
	input wire logic [31:0] sck_pin_sel,
	input wire logic [31:0] dout_pin_sel
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_wait;
		mem_req && !mem_ack;
	endsequence
	sequence s_held;
		mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
	endsequence
	AST_RST_PINS: assert property ($fell(sys_rst) |->
		!mem_req && !sck_out && !dout_out && sck_pin_sel == PSEL_RST) else $error("pins not idle after reset");
	AST_MEM_HOLD: assert property (s_wait |=> s_held)
		else $error("memory request changed before answer");
	AST_MEM_DROP: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after answer");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	AST_OE_SCK: assert property (sck_oe |-> !sck_pin_sel[PSEL_CONNECT])
		else $error("clock driven while disconnected");
	AST_OE_DOUT: assert property (dout_oe |-> !dout_pin_sel[PSEL_CONNECT])
		else $error("data out driven while disconnected");
	AST_PSEL_RD: assert property (reg_rd && reg_addr == OFS_PSEL_CLK |=> reg_rdata == sck_pin_sel)
		else $error("pin select readback differs");
	AST_DONE_RD: assert property (reg_rd && (reg_addr == OFS_RX_DONE || reg_addr == OFS_TX_DONE) |=>
		reg_rdata[31:15] == 17'h0) else $error("byte count too wide");
	AST_SCK_QUIET: assert property (mem_req && !mem_we |-> $stable(sck_out))
		else $error("clock moved during fetch");
	AST_SCK_HALF: assert property ($changed(sck_out) |=> $stable(sck_out) [*3])
		else $error("clock half period too short");
endmodule : spmd_monitor
bind spmd_top spmd_monitor spmd_monitor_i (.*);

// >>> spmd_peer.sv
// memory and serial slave standing on the far side of the master
`timescale 1ns/1ps
module spmd_peer
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_ack,
	input wire logic sck_out,
	input wire logic dout_out,
	output logic din_in,
	input wire logic sel_n,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb,
	input wire logic [7:0] seed
);
	logic [1:0] wait_r;
	logic pend_r;
	logic [7:0] sh;
	int bits;
	logic [39:0] wr_q[$];
	logic [7:0] cap_q[$];
	function automatic logic out_bit(input int i);
		logic [7:0] b;
		b = seed + 8'(i / 8);
		return lsb ? b[i % 8] : b[7 - i % 8];
	endfunction : out_bit
	initial {mem_ack, mem_rdata, din_in, pend_r, wait_r} = 13'h0;
	// answer after one or three cycles; read data keep changing outside an answer
	always @(posedge core_clk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (sys_rst)
			pend_r <= 1'b0;
		else if (pend_r && wait_r == 2'd0)
		begin
			mem_ack <= 1'b1;
			pend_r <= 1'b0;
			mem_rdata <= mem_addr[7:0] ^ 8'h3c;
			if (mem_we)
				wr_q.push_back({mem_addr, mem_wdata});
		end
		else if (pend_r)
			wait_r <= wait_r - 2'd1;
		else if (mem_req && !mem_ack)
		begin
			pend_r <= 1'b1;
			wait_r <= slow ? 2'd2 : 2'd0;
		end
	end
	always @(negedge sel_n)
	begin
		bits = 0;
		din_in = out_bit(0);
	end
	always @(posedge sel_n)
		din_in = ~din_in;
	// sample on the leading edge for phase 0, on the trailing one for phase 1
	always @(sck_out)
	begin
		if (!sel_n && ((sck_out !== cpol) ^ cpha))
		begin
			sh = lsb ? {dout_out, sh[7:1]} : {sh[6:0], dout_out};
			bits++;
			if (bits % 8 == 0)
				cap_q.push_back(sh);
		end
		else if (!sel_n)
			din_in = out_bit(bits);
	end
endmodule : spmd_peer

// >>> spmd_tb_top.sv
// self-checking bench for the dma serial master
`timescale 1ns/1ps
module spmd_tb_top
	import spmd_pkg::*;
;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow = 1'b0;
	logic sel_n = 1'b1;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic lsb = 1'b0;
	logic [7:0] seed = 8'h0;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, mem_addr, sck_pin_sel, dout_pin_sel, din_pin_sel;
	logic [7:0] mem_wdata, mem_rdata;
	logic mem_req, mem_we, mem_ack, sck_out, sck_oe, dout_out, dout_oe, din_in;
	int n_errors = 0;
	int check_count = 0;
	spmd_top spmd_top_i (.*);
	spmd_peer spmd_peer_i (.*);
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic test_done();
		$display("mismatches %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rc(input string what, input logic [11:0] a, input logic [31:0] e);
		@(posedge core_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(what, e, reg_rdata);
	endtask : rc
	task automatic wait_ev(input int ev);
		for (int i = 0; i < 3000; i++)
		begin
			@(posedge core_clk);
			{reg_rd, reg_addr} <= {1'b1, EV_OFS[ev]};
			@(posedge core_clk);
			reg_rd <= 1'b0;
			#1 if (reg_rdata[0] === 1'b1)
				return;
		end
		chk("event wait", 32'h1, 32'h0);
		test_done();
	endtask : wait_ev
	task automatic xfer(input int tn, input int rn, input int mode, input logic [2:0] fmt);
		logic [7:0] fill;
		int n;
		int w;
		n = mode == 1 ? 1 : (tn > rn ? tn : rn);
		fill = 8'($urandom);
		seed <= 8'($urandom);
		slow <= 1'($urandom);
		{cpol, cpha, lsb} <= fmt;
		spmd_peer_i.cap_q.delete();
		spmd_peer_i.wr_q.delete();
		wr(OFS_FORMAT, {29'h0, fmt});
		for (int i = 0; i < 5; i++)
			wr(EV_OFS[i], 32'h0);
		wr(OFS_TX_PTR, 32'h100);
		wr(OFS_RX_PTR, 32'h200);
		wr(OFS_TX_LIMIT, 32'(tn));
		wr(OFS_RX_LIMIT, 32'(rn));
		wr(OFS_FILL, {24'h0, fill});
		sel_n <= 1'b0;
		wr(OFS_START, 32'h1);
		wait_ev(EV_STARTED);
		wr(OFS_TX_PTR, 32'h900);
		wr(OFS_STARTED, 32'h0);
		repeat (40) @(posedge core_clk);
		if (mode == 2)
		begin
			wr(OFS_SUSPEND, 32'h1);
			repeat (400) @(posedge core_clk);
			#1 chk("paused bits", 32'h8, spmd_peer_i.bits);
			chk("paused sck", {31'h0, fmt[2]}, {31'h0, sck_out});
			wr(OFS_RESUME, 32'h1);
		end
		if (mode == 1)
			wr(OFS_STOP, 32'h1);
		wait_ev(mode == 1 ? EV_STOPPED : EV_BOTH_END);
		repeat (4) @(posedge core_clk);
		sel_n <= 1'b1;
		w = mode == 1 ? 1 : rn;
		chk("bits", 32'(8 * n), spmd_peer_i.bits);
		chk("rx writes", 32'(w), 32'(spmd_peer_i.wr_q.size()));
		for (int i = 0; i < n; i++)
			chk("tx byte", i < tn ? 32'(8'(i) ^ 8'h3c) : {24'h0, fill}, {24'h0, spmd_peer_i.cap_q[i]});
		for (int i = 0; i < w; i++)
		begin
			chk("rx addr", 32'h200 + 32'(i), spmd_peer_i.wr_q[i][39:8]);
			chk("rx data", {24'h0, seed + 8'(i)}, {24'h0, spmd_peer_i.wr_q[i][7:0]});
		end
		rc("tx end", OFS_TX_END, 32'h1);
		rc("rx end", OFS_RX_END, 32'h1);
		rc("stopped", OFS_STOPPED, 32'(mode == 1));
		rc("started", OFS_STARTED, 32'h0);
		rc("tx done", OFS_TX_DONE, 32'(mode == 1 ? 1 : tn));
		rc("rx done", OFS_RX_DONE, 32'(w));
	endtask : xfer
	initial
	begin
		int k;
		void'($urandom(32'he2a8));
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rc("format", OFS_FORMAT, 32'h0);
		rc("rate", OFS_BIT_RATE, RATE_RST);
		rc("psel", OFS_PSEL_CLK, PSEL_RST);
		rc("unmapped", 12'h7fc, 32'h0);
		chk("idle pins", 32'h0, {30'h0, sck_out, dout_out});
		wr(OFS_PSEL_CLK, 32'h0);
		wr(OFS_PSEL_DOUT, 32'h1);
		wr(OFS_PSEL_DIN, 32'h2);
		repeat (2) @(posedge core_clk);
		#1 chk("oe off", 32'h0, {30'h0, sck_oe, dout_oe});
		chk("dout sel", 32'h1, dout_pin_sel);
		chk("din sel", 32'h2, din_pin_sel);
		wr(OFS_ENABLE, 32'h1);
		wr(OFS_BIT_RATE, 32'h80000000);
		wr(OFS_IRQ_SET, 32'h1f);
		wr(OFS_IRQ_CLR, 32'h05);
		rc("irq", OFS_IRQ_SET, 32'h1a);
		chk("oe on", 32'h3, {30'h0, sck_oe, dout_oe});
		rc("psel on", OFS_PSEL_CLK, 32'h0);
		wr(OFS_START, 32'h0);
		repeat (20) @(posedge core_clk);
		rc("no start", OFS_STARTED, 32'h0);
		$display("test registers done");
		for (int m = 0; m < 8; m++)
		begin
			k = 2 + $urandom % 3;
			xfer(k, m[0] ? k + 1 : k - 1, 0, m[2:0]);
			$display("test mode %0d done", m);
		end
		xfer(3, 3, 1, 3'h0);
		$display("test stop done");
		xfer(3, 3, 2, 3'h5);
		$display("test suspend done");
		wr(OFS_LINKS, 32'h1);
		wr(OFS_START, 32'h1);
		wait_ev(EV_STARTED);
		wr(OFS_STARTED, 32'h0);
		wait_ev(EV_STARTED);
		wr(OFS_LINKS, 32'h0);
		wr(OFS_STOP, 32'h1);
		wait_ev(EV_STOPPED);
		wr(OFS_ENABLE, 32'h0);
		repeat (2) @(posedge core_clk);
		#1 chk("oe end", 32'h0, {30'h0, sck_oe, dout_oe});
		$display("test link done");
		test_done();
	end
endmodule : spmd_tb_top
